//--- core/rwu_defs.vh
// Constants for the reset and watchdog unit
`ifndef RWU_DEFS_VH
`define RWU_DEFS_VH
`define RWU_WDT_ADDR 8'hd8
`define RWU_WDT_RESET 8'hfe
`define RWU_BIT_ACT 0
`define RWU_BIT_SWRST 1
`define RWU_STAB_CYCLES 2048
`define RWU_TICK_CYCLES 3072
`define RWU_RESET_VECTOR 12'hffe
`define RWU_STACK_DEPTH 6
`define RWU_CNT_RESET 7'h7f
`define RWU_CNT_END 7'h40
`endif

//--- core/rwu_reset_watchdog.v
// Reset sequencer and digital watchdog
//
// What this block does
// [RQ1] During reset ports are inputs with pull-ups and no instruction runs.
// [RQ2] Internal reset stays asserted 2048 clocks after external reset release.
// [RQ3] Initialization starts the cycle right after the stabilization delay.
// [RQ4] Watchdog end of count asserts internal reset and reinitializes the counter.
// [RQ5] Watchdog reset takes the same path as pin reset, full delay included.
// [RQ6] Any reset clears the call stack and loads PC with the reset vector.
// [RQ7] After reset core is in non-maskable context until return from interrupt.
// [RQ8] After that return, a pending interrupt is serviced first.
// [RQ9] Enabled watchdog decrements and resets the device when count reaches zero.
// [RQ10] Writing a new count reloads the counter and prevents reset.
// [RQ11] Software option: disabled until activate bit set, then only reset disables.
// [RQ12] While the watchdog is disabled, stop mode may halt the oscillator.
// [RQ13] Hardware option: always enabled, stop acts as wait, counting continues.
// [RQ14] Leaving stop on an interrupt, the watchdog resumes counting.
// [RQ15] Watchdog register sits at data address 0xd8.
// [RQ16] Register resets to 0xfe: activate clear, reset bit and count bits set.
// [RQ17] Software-reset bit going to zero triggers an immediate reset.
// [RQ18] Count bits are bit-reversed: register bit 7 is counter LSB.
// [RQ19] Reset fires when counter bit 6 falls to zero.
// [RQ20] Period bits select 64 timeouts from 3072 to 196608 clocks.
// [RQ21] Activate bit is bit 0; hardware option reads one, writes ignored.
// [RQ22] With activate clear the counter is a free 7-bit timer, no reset; here a write with bit 1 clear still resets.
// [RQ23] At least 28 instructions run after activation before any reset.
// [RQ24] Counter decrements once every 3072 oscillator clocks.
// [RQ25] Reads return counter, reset bit and activate bit in register layout.
`timescale 1ns/1ns
`include "rwu_defs.vh"
`default_nettype none
module rwu_reset_watchdog #(
   parameter STAB_CYCLES = `RWU_STAB_CYCLES,
   parameter TICK_CYCLES = `RWU_TICK_CYCLES
) (
   input wire i_mclk,
   input wire i_rst,
   input wire i_hw_option,
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire i_stop_req,
   input wire i_wake_irq,
   input wire i_call,
   input wire i_ret,
   input wire i_return_from_interrupt,
   input wire [11:0] i_call_pc,
   input wire i_irq_pending,
   output reg [7:0] o_rdata,
   output reg o_core_rst,
   output reg o_port_pullup_in,
   output reg o_init_start,
   output reg [11:0] o_pc_load,
   output reg o_nmi_ctx,
   output reg o_irq_service,
   output reg o_osc_halt,
   output reg o_wdt_active
);
   // Reset sequencer
   reg [11:0] stab_cnt_ff;
   reg [11:0] nxt_stab_cnt;
   reg busy_ff;
   reg nxt_busy;
   reg nxt_core_rst;
   reg nxt_port_pullup_in;
   reg nxt_init_start;

   // Watchdog
   reg [11:0] tick_cnt_ff;
   reg [11:0] nxt_tick_cnt;
   reg [6:0] wdt_cnt_ff;
   reg [6:0] nxt_wdt_cnt;
   reg act_ff;
   reg nxt_act;
   reg stopped_ff;
   reg nxt_stopped;
   reg wd_fire_ff;
   reg nxt_wd_fire;
   reg [7:0] nxt_rdata;
   reg nxt_osc_halt;
   reg nxt_wdt_active;

   // Core context
   reg [11:0] stack_ff [0:`RWU_STACK_DEPTH-1];
   reg [11:0] nxt_stack [0:`RWU_STACK_DEPTH-1];
   reg [2:0] depth_ff;
   reg [2:0] nxt_depth;
   reg [11:0] nxt_pc_load;
   reg nxt_nmi_ctx;
   reg nxt_irq_service;
   integer k;
   integer j;

   // Decoded conditions
   wire wr_hit;
   wire rd_hit;
   wire enabled;
   wire tick;
   wire at_end;
   wire wd_end;
   wire sw_rst;
   wire seq_clear;
   wire hold_clear;
   wire stab_done;
   wire stop_halts;
   wire prescale_run;
   wire pop_req;
   wire pop_ok;
   wire push_ok;
   wire [6:0] wr_cnt;
   wire [7:0] rd_val;

   assign wr_hit = i_wr && (i_addr == `RWU_WDT_ADDR); // RQ15
   assign rd_hit = i_rd && (i_addr == `RWU_WDT_ADDR); // RQ15
   // Hardware option forces the watchdog on whatever the activate bit holds
   assign enabled = act_ff || i_hw_option; // RQ13 RQ21
   assign prescale_run = !stopped_ff; // RQ14
   assign tick = (tick_cnt_ff == TICK_CYCLES - 1) && prescale_run; // RQ24
   assign at_end = (wdt_cnt_ff == `RWU_CNT_END); // RQ19
   // Counter bit 6 about to fall ends the count; a reload in the same cycle wins
   assign wd_end = enabled && tick && !wr_hit && at_end; // RQ9 RQ19
   assign sw_rst = wr_hit && !i_wdata[`RWU_BIT_SWRST] && !busy_ff; // RQ17
   assign seq_clear = i_rst || wd_fire_ff; // RQ5
   assign hold_clear = i_rst || busy_ff; // RQ6
   assign stab_done = (stab_cnt_ff == STAB_CYCLES - 1); // RQ2
   assign stop_halts = i_stop_req && !enabled; // RQ12
   assign pop_req = i_ret || i_return_from_interrupt;
   assign pop_ok = (depth_ff != 3'h0);
   assign push_ok = (depth_ff != `RWU_STACK_DEPTH);

   // Register bits 7..2 carry counter bits 0..5; bit 1 carries counter bit 6
   assign wr_cnt[0] = i_wdata[7]; // RQ18
   assign wr_cnt[1] = i_wdata[6];
   assign wr_cnt[2] = i_wdata[5];
   assign wr_cnt[3] = i_wdata[4];
   assign wr_cnt[4] = i_wdata[3];
   assign wr_cnt[5] = i_wdata[2];
   assign wr_cnt[6] = i_wdata[`RWU_BIT_SWRST]; // RQ22

   assign rd_val[7] = wdt_cnt_ff[0]; // RQ25
   assign rd_val[6] = wdt_cnt_ff[1];
   assign rd_val[5] = wdt_cnt_ff[2];
   assign rd_val[4] = wdt_cnt_ff[3];
   assign rd_val[3] = wdt_cnt_ff[4];
   assign rd_val[2] = wdt_cnt_ff[5];
   assign rd_val[`RWU_BIT_SWRST] = wdt_cnt_ff[6];
   assign rd_val[`RWU_BIT_ACT] = enabled; // RQ21

   // Reset sequencer: external, watchdog and software reset share one delay
   always @* begin
      nxt_stab_cnt = stab_cnt_ff;
      nxt_busy = busy_ff;
      nxt_core_rst = o_core_rst;
      nxt_port_pullup_in = o_port_pullup_in;
      if (seq_clear) begin
         nxt_stab_cnt = 12'h000; // RQ5
         nxt_busy = 1'b1;
         nxt_core_rst = 1'b1; // RQ2
         nxt_port_pullup_in = 1'b1; // RQ1
      end else if (busy_ff) begin
         if (stab_done) begin
            nxt_busy = 1'b0;
            nxt_core_rst = 1'b0; // RQ2
            nxt_port_pullup_in = 1'b0; // RQ1
         end else begin
            nxt_stab_cnt = stab_cnt_ff + 12'h001;
         end
      end
   end

   always @* begin
      nxt_init_start = 1'b0;
      if (!seq_clear && busy_ff && stab_done) begin
         nxt_init_start = 1'b1; // RQ3
      end
   end

   always @(posedge i_mclk) begin
      stab_cnt_ff <= nxt_stab_cnt;
   end

   always @(posedge i_mclk) begin
      busy_ff <= nxt_busy;
   end

   always @(posedge i_mclk) begin
      o_core_rst <= nxt_core_rst;
   end

   always @(posedge i_mclk) begin
      o_port_pullup_in <= nxt_port_pullup_in;
   end

   always @(posedge i_mclk) begin
      o_init_start <= nxt_init_start;
   end

   // Stop only halts the oscillator with the watchdog off
   always @* begin
      nxt_stopped = stopped_ff;
      nxt_osc_halt = 1'b0;
      if (hold_clear) begin
         nxt_stopped = 1'b0;
      end else begin
         if (i_wake_irq) begin
            nxt_stopped = 1'b0; // RQ14
         end else if (stop_halts) begin
            nxt_stopped = 1'b1; // RQ12
         end
         // With the watchdog on a stop acts as a wait and the clock keeps running
         nxt_osc_halt = (stopped_ff || stop_halts) && !i_wake_irq; // RQ12 RQ13
      end
   end

   // A write restarts the prescaler, so a fresh count always gets full intervals
   always @* begin
      nxt_tick_cnt = tick_cnt_ff;
      if (hold_clear) begin
         nxt_tick_cnt = 12'h000;
      end else if (tick || wr_hit) begin
         nxt_tick_cnt = 12'h000; // RQ23
      end else if (prescale_run) begin
         nxt_tick_cnt = tick_cnt_ff + 12'h001; // RQ24
      end
   end

   // Downcounter and activate bit
   always @* begin
      nxt_wdt_cnt = wdt_cnt_ff;
      nxt_act = act_ff;
      if (hold_clear) begin
         nxt_wdt_cnt = `RWU_CNT_RESET; // RQ16 RQ4
         nxt_act = 1'b0; // RQ16
      end else if (wr_hit) begin
         nxt_wdt_cnt = wr_cnt; // RQ10
         // Once set only a reset clears it
         if (i_wdata[`RWU_BIT_ACT]) begin
            nxt_act = 1'b1; // RQ11
         end
      end else if (tick) begin
         // Disabled, the counter wraps as a free timer and its end of count never resets
         nxt_wdt_cnt = wdt_cnt_ff - 7'h01; // RQ22 RQ20
      end
   end

   // Reset request from end of count or a cleared software-reset bit
   always @* begin
      nxt_wd_fire = 1'b0;
      if (!hold_clear) begin
         nxt_wd_fire = wd_end || sw_rst; // RQ4 RQ17
      end
   end

   always @* begin
      nxt_rdata = 8'h00;
      if (!hold_clear && rd_hit) begin
         nxt_rdata = rd_val; // RQ25
      end
   end

   always @* begin
      nxt_wdt_active = 1'b0;
      if (!hold_clear) begin
         nxt_wdt_active = enabled; // RQ11 RQ13
      end
   end

   always @(posedge i_mclk) begin
      tick_cnt_ff <= nxt_tick_cnt;
   end

   always @(posedge i_mclk) begin
      wdt_cnt_ff <= nxt_wdt_cnt;
   end

   always @(posedge i_mclk) begin
      act_ff <= nxt_act;
   end

   always @(posedge i_mclk) begin
      stopped_ff <= nxt_stopped;
   end

   always @(posedge i_mclk) begin
      wd_fire_ff <= nxt_wd_fire;
   end

   always @(posedge i_mclk) begin
      o_rdata <= nxt_rdata;
   end

   always @(posedge i_mclk) begin
      o_osc_halt <= nxt_osc_halt;
   end

   always @(posedge i_mclk) begin
      o_wdt_active <= nxt_wdt_active;
   end

   // Stack: a push shifts every level down and the deepest level is lost
   always @* begin
      for (k = 0; k < `RWU_STACK_DEPTH; k = k + 1) begin
         nxt_stack[k] = stack_ff[k];
      end
      if (hold_clear) begin
         for (k = 0; k < `RWU_STACK_DEPTH; k = k + 1) begin
            nxt_stack[k] = 12'h000; // RQ6
         end
      end else if (i_call) begin
         nxt_stack[0] = i_call_pc;
         for (k = 1; k < `RWU_STACK_DEPTH; k = k + 1) begin
            nxt_stack[k] = stack_ff[k-1];
         end
      end else if (pop_req) begin
         for (k = 0; k < `RWU_STACK_DEPTH - 1; k = k + 1) begin
            nxt_stack[k] = stack_ff[k+1];
         end
      end
   end

   // Depth, popped return address and context
   always @* begin
      nxt_depth = depth_ff;
      nxt_pc_load = o_pc_load;
      nxt_nmi_ctx = o_nmi_ctx;
      nxt_irq_service = 1'b0;
      if (hold_clear) begin
         nxt_depth = 3'h0; // RQ6
         nxt_pc_load = `RWU_RESET_VECTOR; // RQ6
         nxt_nmi_ctx = 1'b1; // RQ7
      end else if (i_call) begin
         // Depth saturates, so returns past the deepest call are not tracked
         if (push_ok) begin
            nxt_depth = depth_ff + 3'h1;
         end
      end else if (pop_req) begin
         // An empty stack leaves the program counter to run on
         if (pop_ok) begin
            nxt_pc_load = stack_ff[0];
            nxt_depth = depth_ff - 3'h1;
         end
         if (i_return_from_interrupt) begin
            nxt_nmi_ctx = 1'b0; // RQ7
            nxt_irq_service = i_irq_pending; // RQ8
         end
      end
   end

   // Storage cells carry no reset of their own; the context logic clears them
   always @(posedge i_mclk) begin
      for (j = 0; j < `RWU_STACK_DEPTH; j = j + 1) begin
         stack_ff[j] <= nxt_stack[j];
      end
   end

   always @(posedge i_mclk) begin
      depth_ff <= nxt_depth;
   end

   always @(posedge i_mclk) begin
      o_pc_load <= nxt_pc_load;
   end

   always @(posedge i_mclk) begin
      o_nmi_ctx <= nxt_nmi_ctx;
   end

   always @(posedge i_mclk) begin
      o_irq_service <= nxt_irq_service;
   end
endmodule
`default_nettype wire

//--- verification/rwu_asserts.sv
// Port checker for the reset and watchdog unit
`timescale 1ns/1ns
`default_nettype none
module rwu_asserts (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic o_core_rst,
   input wire logic o_port_pullup_in,
   input wire logic o_init_start,
   input wire logic [11:0] o_pc_load,
   input wire logic o_nmi_ctx,
   input wire logic o_osc_halt,
   input wire logic o_wdt_active
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   AST_PULL: assert property (o_core_rst |-> o_port_pullup_in) else $error("pull-up off");
   AST_HOLD: assert property ($fell(i_rst) |-> o_core_rst [*8]) else $error("reset short");
   AST_INIT: assert property ($fell(o_core_rst) |-> o_init_start) else $error("no init");
   AST_VEC: assert property (o_core_rst && $past(o_core_rst) |-> o_pc_load == 12'hffe && o_nmi_ctx)
      else $error("bad vector");
   AST_SOFT: assert property (i_wr && i_addr == 8'hd8 && !i_wdata[1] && !o_core_rst |-> ##2 o_core_rst)
      else $error("no soft reset");
   AST_RD0: assert property (i_rd && i_addr != 8'hd8 |=> o_rdata == 8'h00) else $error("unmapped data");
   AST_RDQ: assert property (o_rdata != 8'h00 |-> $past(i_rd)) else $error("stray data");
   // A running watchdog needs the clock, so halting is only legal while it is off
   AST_HALT: assert property (o_osc_halt |-> !o_wdt_active) else $error("halt with watchdog");
endmodule
bind rwu_reset_watchdog rwu_asserts chk_u (.*);
`default_nettype wire

//--- verification/rwu_reset_watchdog_tb.sv
// Testbench for the reset and watchdog unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(s,e,a) begin compares++; if ((a) !== (e)) begin err_count++; $display("mismatch %s exp %0h got %0h", s, e, a); end end
module rwu_reset_watchdog_tb;
   logic i_mclk = 0, i_rst = 1, i_hw_option = 0, i_wr = 0, i_rd = 0, i_return_from_interrupt = 0, i_irq_pending = 0;
   logic i_stop_req = 0, i_wake_irq = 0;
   localparam int STAB = 16;
   logic [7:0] i_addr = 0, i_wdata = 0;
   wire [7:0] o_rdata;
   wire [11:0] o_pc_load;
   wire o_core_rst, o_port_pullup_in, o_init_start, o_nmi_ctx, o_irq_service, o_osc_halt, o_wdt_active;
   int err_count = 0, compares = 0, n;
   always #50 i_mclk = ~i_mclk;
   // Short counts keep the run brief; expectations follow them
   rwu_reset_watchdog #(.STAB_CYCLES(STAB), .TICK_CYCLES(8)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_hw_option(i_hw_option), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
      .i_stop_req(i_stop_req), .i_wake_irq(i_wake_irq), .i_call(1'b0), .i_ret(1'b0), .i_return_from_interrupt(i_return_from_interrupt),
      .i_call_pc(12'h000), .i_irq_pending(i_irq_pending), .o_rdata(o_rdata), .o_core_rst(o_core_rst),
      .o_port_pullup_in(o_port_pullup_in), .o_init_start(o_init_start), .o_pc_load(o_pc_load),
      .o_nmi_ctx(o_nmi_ctx), .o_irq_service(o_irq_service), .o_osc_halt(o_osc_halt),
      .o_wdt_active(o_wdt_active));
   task automatic wr(input logic [7:0] d);
      @(posedge i_mclk);
      i_addr <= 8'hd8;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(negedge i_mclk);
      `CHK("rdata", e, o_rdata)
   endtask
   task automatic wait_init;
      n = 0;
      do begin
         @(posedge i_mclk);
         #1 n++;
      end while (o_init_start !== 1'b1 && n < 400);
   endtask
   task automatic do_rst(input logic hw);
      @(posedge i_mclk);
      i_hw_option <= hw;
      i_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      `CHK("pull", 1'b1, o_port_pullup_in)
      `CHK("vec", 12'hffe, o_pc_load)
      i_rst <= 1'b0;
      wait_init;
      `CHK("stab", STAB, n)
   endtask
   task automatic end_sim;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      do_rst(1'b0);
      `CHK("nmi", 1'b1, o_nmi_ctx)
      rd(8'hd8, 8'hfe);
      rd(8'h55, 8'h00);
      wr(8'h7e);
      rd(8'hd8, 8'h7e);
      `CHK("off", 1'b0, o_wdt_active)
      @(posedge i_mclk);
      i_stop_req <= 1'b1;
      @(posedge i_mclk);
      i_stop_req <= 1'b0;
      @(negedge i_mclk);
      `CHK("halt", 1'b1, o_osc_halt)
      repeat (10) @(posedge i_mclk);
      rd(8'hd8, 8'h7e);
      @(posedge i_mclk);
      i_wake_irq <= 1'b1;
      @(posedge i_mclk);
      i_wake_irq <= 1'b0;
      @(negedge i_mclk);
      `CHK("wake", 1'b0, o_osc_halt)
      repeat (4) @(posedge i_mclk);
      rd(8'hd8, 8'hbe);
      @(posedge i_mclk);
      i_irq_pending <= 1'b1;
      i_return_from_interrupt <= 1'b1;
      @(posedge i_mclk);
      i_return_from_interrupt <= 1'b0;
      n = 0;
      repeat (4) @(posedge i_mclk) n += o_irq_service;
      `CHK("irq", 1, n)
      `CHK("ctx", 1'b0, o_nmi_ctx)
      i_irq_pending <= 1'b0;
      wr(8'hff);
      rd(8'hd8, 8'hff);
      `CHK("act", 1'b1, o_wdt_active)
      repeat (20) wr(8'h83);
      `CHK("kept", 1'b0, o_core_rst)
      n = 0;
      while (o_core_rst !== 1'b1 && n < 99) begin
         @(posedge i_mclk);
         #1 n++;
      end
      `CHK("tmo", 1'b1, n > 10 && n < 30)
      wait_init;
      `CHK("wrst", 1'b1, n >= STAB)
      rd(8'hd8, 8'hfe);
      wr(8'hfd);
      wait_init;
      `CHK("srst", 1'b1, n >= STAB)
      do_rst(1'b1);
      rd(8'hd8, 8'hff);
      wr(8'h82);
      rd(8'hd8, 8'h83);
      `CHK("hw", 1'b1, o_wdt_active)
      @(posedge i_mclk);
      i_stop_req <= 1'b1;
      @(posedge i_mclk);
      i_stop_req <= 1'b0;
      @(negedge i_mclk);
      `CHK("nohalt", 1'b0, o_osc_halt)
      end_sim;
   end
   initial begin
      #200000;
      err_count++;
      end_sim;
   end
endmodule
`default_nettype wire
